// ---- src/vssf_pkg.sv ----
// constants shared by the output-voltage slew, scale and floor block
// assumes a command-level port fed by the device's PMBus engine on the same clock
//
// Overview of operation
// - slew exponent is fixed at 11010 (minus six); writes cannot change it
// - slew mantissa resets to 60, giving a 1 mV/us ramp
// - slew mantissa picks one of eight ramp rates by fixed bucket limits
// - scale checks only the low three mantissa bits: 100 (ratio 1, default) or 010 (ratio 0.5)
// - bad scale write keeps old value, flags cml and ivd, raises alert
// - scale exponent is fixed at 11110 (minus two); writes cannot change it
// - store-all command copies the current scale word to nonvolatile memory
// - loop slave refuses scale and floor commands: ignore, nack, ivc, alert
// - scale changes are accepted with output on or off, except as loop slave
// - floor bounds every attempt to set the effective output target while output is on
// - floor word: implied exponent minus nine, top four bits read-only zero
// - target below floor with output on clamps reference; maximum dominates
// - clamp sets other-fault, output-word and limit warning bits, raises alert
// - at ratio 1 floor resets to 179, valid 179 to 768
// - at ratio 0.5 floor default is 358, valid 358 to 1536; the floor register keeps its 179 reset value when the ratio changes
// - floor write at or above maximum with output on also clamps and flags
// - selected slew rate paces reference changes in normal and turn-off delay
package vssf_pkg;
  // command codes
  localparam logic [7:0]  CMD_SLEW      = 8'h27;
  localparam logic [7:0]  CMD_SCALE     = 8'h29;
  localparam logic [7:0]  CMD_FLOOR     = 8'h2B;
  localparam logic [7:0]  CMD_STORE_ALL = 8'h11;
  // fixed exponents
  localparam logic [4:0]  SLEW_EXP      = 5'h1A;
  localparam logic [4:0]  SCALE_EXP     = 5'h1E;
  // reset values and scale codes
  localparam logic [10:0] SLEW_RST      = 11'h03C;
  localparam logic [2:0]  SCALE_ONE     = 3'h4;
  localparam logic [2:0]  SCALE_HALF    = 3'h2;
  localparam logic [11:0] FLOOR_RST     = 12'h0B3;
  localparam logic [11:0] FLOOR_MAX_ONE = 12'h300;
  localparam logic [11:0] FLOOR_DEF_HALF = 12'h166;
  localparam logic [11:0] FLOOR_MAX_HALF = 12'h600;
  // upper limits of the slew buckets, mantissa units
  localparam logic [10:0] SLEW_B0 = 11'h005;
  localparam logic [10:0] SLEW_B1 = 11'h007;
  localparam logic [10:0] SLEW_B2 = 11'h00C;
  localparam logic [10:0] SLEW_B3 = 11'h011;
  localparam logic [10:0] SLEW_B4 = 11'h019;
  localparam logic [10:0] SLEW_B5 = 11'h02F;
  localparam logic [10:0] SLEW_B6 = 11'h04F;
  // ramp rates in uV/us per bucket, and timing
  localparam int RATE_UV_US [8] = '{67, 100, 143, 222, 333, 500, 1000, 1500};
  localparam int CLK_PS       = 4000;
  localparam int LSB_UV_X1000 = 1953125;
  localparam logic [2:0] RATE_RST_SEL = 3'h6;
  // pacing state
  typedef enum logic [1:0] {
    VSSF_FOLLOW = 2'b00,
    VSSF_RAMP   = 2'b01,
    VSSF_HOLD   = 2'b10
  } vssf_ramp_type;
endpackage

// ---- src/vssf_floor_if.sv ----
// bundle between the register logic and the floor clamp
// assumes both ends sit on the same clock
`timescale 1ns/1ns
interface vssf_floor_if;
  logic        ratio_half;
  logic        output_on;
  logic        floor_write;
  logic        check;
  logic [15:0] floor_val;
  logic [15:0] max_val;
  logic [15:0] equiv_val;
  logic [15:0] ref_tgt;
  logic        clamp_hit;
  modport regs  (output ratio_half, output_on, output floor_write, output check,
                 output floor_val, output max_val, output equiv_val,
                 input ref_tgt, input clamp_hit);
  modport clamp (input ratio_half, input output_on, input floor_write, input check,
                 input floor_val, input max_val, input equiv_val,
                 output ref_tgt, output clamp_hit);
endinterface

// ---- src/vssf_floor_clamp.sv ----
// floor clamp: bounds the effective target and reports clamp events
// assumes equivalent target and maximum come from the wider command block
`timescale 1ns/1ns
module vssf_floor_clamp (
  vssf_floor_if.clamp fl
);
  // scale a 2^-9 word by the feedback ratio
  function automatic logic [15:0] vssf_scale(input logic [15:0] v, input logic half);
    vssf_scale = half ? {1'b0, v[15:1]} : v;
  endfunction

  wire        max_below = fl.max_val < fl.floor_val;
  wire [15:0] low_bound = max_below ? fl.max_val : fl.floor_val;
  wire        eq_low    = fl.equiv_val < fl.floor_val;
  wire        min_ge    = fl.floor_write && (fl.floor_val >= fl.max_val);
  wire [15:0] bounded;

  // clamp, maximum dominates
  // a target under the floor lands on the lower of floor and maximum
  assign bounded    = (eq_low || min_ge) ? low_bound : fl.equiv_val;
  assign fl.ref_tgt = vssf_scale(fl.output_on ? bounded : fl.equiv_val, fl.ratio_half);
  assign fl.clamp_hit = fl.check && fl.output_on && (eq_low || min_ge);
endmodule

// ---- src/vssf_regs.sv ----
// slew, feedback-scale and output-floor command registers with reference pacing
// assumes commands arrive decoded from the PMBus engine, one per valid pulse,
// and that status registers and the alert pin live in a neighbouring block
`timescale 1ns/1ns
module vssf_regs #(
  parameter int STEP_UV_X1000 = vssf_pkg::LSB_UV_X1000
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic             cmd_done,
  output logic             cmd_nack,
  output logic [15:0]      cmd_rdata,
  input  wire logic        loop_slave_pin,
  input  wire logic        output_on,
  input  wire logic        toff_delay_active,
  input  wire logic        soft_ramp_active,
  input  wire logic        target_attempt,
  input  wire logic [15:0] effective_output_target,
  input  wire logic [15:0] vout_max,
  output logic [15:0]      vref_out,
  output logic [2:0]       slew_rate_sel,
  output logic             nvm_store,
  output logic [15:0]      nvm_scale_word,
  output logic             set_cml,
  output logic             set_ivd,
  output logic             set_ivc,
  output logic             set_oth,
  output logic             set_vfw,
  output logic             set_vout_warn,
  output logic             alert_req
);
  // bucket a slew mantissa into one of eight rates
  function automatic logic [2:0] vssf_bucket(input logic [10:0] m);
    if (m <= vssf_pkg::SLEW_B0) begin
      vssf_bucket = 3'h0;
    end else if (m <= vssf_pkg::SLEW_B1) begin
      vssf_bucket = 3'h1;
    end else if (m <= vssf_pkg::SLEW_B2) begin
      vssf_bucket = 3'h2;
    end else if (m <= vssf_pkg::SLEW_B3) begin
      vssf_bucket = 3'h3;
    end else if (m <= vssf_pkg::SLEW_B4) begin
      vssf_bucket = 3'h4;
    end else if (m <= vssf_pkg::SLEW_B5) begin
      vssf_bucket = 3'h5;
    end else if (m <= vssf_pkg::SLEW_B6) begin
      vssf_bucket = 3'h6;
    end else begin
      vssf_bucket = 3'h7;
    end
  endfunction

  // cycles per one-LSB reference step at a given bucket, never below one
  function automatic logic [15:0] vssf_period(input logic [2:0] sel);
    int p;
    p = STEP_UV_X1000 / vssf_pkg::RATE_UV_US[sel] * 1000 / vssf_pkg::CLK_PS;
    if (p < 1) begin
      p = 1;
    end
    if (p > 65535) begin
      p = 65535;
    end
    vssf_period = p[15:0];
  endfunction

  // registers
  logic [10:0] slew_q;
  logic [2:0]  scale_q;
  logic [11:0] floor_q;
  logic        ls_meta_q;
  logic        ls_q;
  logic        done_q;
  logic        nack_q;
  logic [15:0] rdata_q;
  logic        store_q;
  logic [15:0] nvm_word_q;
  logic        cml_q;
  logic        ivd_q;
  logic        ivc_q;
  logic        clamp_q;
  logic        floor_wr_q;
  logic        check_q;
  logic [15:0] vref_q;
  logic [15:0] tgt_q;
  logic [15:0] step_cnt_q;
  logic [2:0]  rate_q;
  vssf_pkg::vssf_ramp_type ramp_q;
  vssf_pkg::vssf_ramp_type ramp_d;

  vssf_floor_if fl ();

  vssf_floor_clamp u_clamp (
    .fl (fl.clamp)
  );

  // command decode
  wire hit_slew  = cmd_code == vssf_pkg::CMD_SLEW;
  wire hit_scale = cmd_code == vssf_pkg::CMD_SCALE;
  wire hit_floor = cmd_code == vssf_pkg::CMD_FLOOR;
  wire hit_store = cmd_code == vssf_pkg::CMD_STORE_ALL;
  wire hit_any   = hit_slew || hit_scale || hit_floor || hit_store;
  wire refused   = cmd_valid && ls_q && (hit_slew || hit_scale || hit_floor);
  wire accepted  = cmd_valid && hit_any && !refused;
  wire wr_slew   = accepted && cmd_write && hit_slew;
  wire wr_scale  = accepted && cmd_write && hit_scale;
  wire wr_floor  = accepted && cmd_write && hit_floor;
  wire do_store  = accepted && cmd_write && hit_store;

  wire scale_ok  = (cmd_wdata[2:0] == vssf_pkg::SCALE_ONE) ||
                   (cmd_wdata[2:0] == vssf_pkg::SCALE_HALF);
  wire scale_bad = wr_scale && !scale_ok;

  // read-back words with read-only fields at their fixed values
  // slew exponent fixed
  wire [15:0] slew_word  = {vssf_pkg::SLEW_EXP, slew_q};
  wire [15:0] scale_word = {vssf_pkg::SCALE_EXP, 8'h00, scale_q};
  wire [15:0] floor_word = {4'h0, floor_q};
  wire [15:0] rd_sel = hit_slew  ? slew_word  :
                       hit_scale ? scale_word :
                       hit_floor ? floor_word : 16'h0000;

  // drive the clamp bundle from the stored limits
  // half ratio halves the reference after the clamp
  assign fl.ratio_half  = scale_q == vssf_pkg::SCALE_HALF;
  assign fl.output_on   = output_on;
  assign fl.floor_write = floor_wr_q;
  assign fl.check       = check_q;
  assign fl.floor_val   = {4'h0, floor_q};
  assign fl.max_val     = vout_max;
  assign fl.equiv_val   = effective_output_target;

  // loop-slave strap comes from a pin, so two flops before use
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ls_meta_q <= 1'b0;
      ls_q      <= 1'b0;
    end else begin
      ls_meta_q <= loop_slave_pin;
      ls_q      <= ls_meta_q;
    end
  end

  // slew mantissa; exponent is never stored so writes cannot touch it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slew_q <= vssf_pkg::SLEW_RST;
    end else if (wr_slew) begin
      slew_q <= cmd_wdata[10:0];
    end
  end

  // feedback scale; taken in any output state, no gating on output_on
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scale_q <= vssf_pkg::SCALE_ONE;
    end else if (wr_scale && scale_ok) begin
      scale_q <= cmd_wdata[2:0];
    end
  end

  // output floor, low twelve bits writable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      floor_q <= vssf_pkg::FLOOR_RST;
    end else if (wr_floor) begin
      floor_q <= cmd_wdata[11:0];
    end
  end

  // command answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_q  <= 1'b0;
      nack_q  <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      done_q  <= cmd_valid;
      nack_q  <= cmd_valid && !accepted;
      rdata_q <= (accepted && !cmd_write) ? rd_sel : 16'h0000;
    end
  end

  // store-all: hand the scale word to the nonvolatile writer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      store_q    <= 1'b0;
      nvm_word_q <= 16'h0000;
    end else begin
      store_q <= do_store;
      if (do_store) begin
        nvm_word_q <= scale_word;
      end
    end
  end

  // fault pulses for the status block
  // pulses only: the sticky status bits and the alert pin live next door
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cml_q <= 1'b0;
      ivd_q <= 1'b0;
      ivc_q <= 1'b0;
    end else begin
      cml_q <= scale_bad;
      ivd_q <= scale_bad;
      ivc_q <= refused;
    end
  end

  // any attempt to move the target is checked one cycle later, once the
  // written limit has landed, so the clamp sees the new floor or ratio
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      check_q    <= 1'b0;
      floor_wr_q <= 1'b0;
      clamp_q    <= 1'b0;
    end else begin
      check_q    <= target_attempt || wr_floor || (wr_scale && scale_ok);
      floor_wr_q <= wr_floor;
      clamp_q    <= fl.clamp_hit;
    end
  end

  // clamped target is registered before the pacer sees it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tgt_q  <= 16'h0000;
      rate_q <= vssf_pkg::RATE_RST_SEL;
    end else begin
      tgt_q  <= fl.ref_tgt;
      rate_q <= vssf_bucket(slew_q);
    end
  end

  // pacing mode: soft ramps and an idle output bypass the slew limiter,
  // since their own ramp commands govern them elsewhere
  always_comb begin
    case (ramp_q)
      vssf_pkg::VSSF_FOLLOW: begin
        ramp_d = (output_on && !soft_ramp_active) ? vssf_pkg::VSSF_HOLD
                                                   : vssf_pkg::VSSF_FOLLOW;
      end
      vssf_pkg::VSSF_HOLD: begin
        if (!output_on || soft_ramp_active) begin
          ramp_d = vssf_pkg::VSSF_FOLLOW;
        end else if (vref_q != tgt_q) begin
          ramp_d = vssf_pkg::VSSF_RAMP;
        end else begin
          ramp_d = vssf_pkg::VSSF_HOLD;
        end
      end
      vssf_pkg::VSSF_RAMP: begin
        if (!output_on || soft_ramp_active) begin
          ramp_d = vssf_pkg::VSSF_FOLLOW;
        end else if (vref_q == tgt_q) begin
          ramp_d = vssf_pkg::VSSF_HOLD;
        end else begin
          ramp_d = vssf_pkg::VSSF_RAMP;
        end
      end
      default: begin
        ramp_d = vssf_pkg::VSSF_FOLLOW;
      end
    endcase
  end

  // pacing mode register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ramp_q <= vssf_pkg::VSSF_FOLLOW;
    end else begin
      ramp_q <= ramp_d;
    end
  end

  // step enable: one pulse per reference LSB at the selected rate
  wire step_en = step_cnt_q == 16'h0000;
  // turn-off delay keeps the output on, so it paces the same way
  wire pacing  = (ramp_q == vssf_pkg::VSSF_RAMP) && (output_on || toff_delay_active);

  // reload while idle, so the first paced step waits a full period
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      step_cnt_q <= 16'h0000;
    end else if (!pacing || step_en) begin
      step_cnt_q <= vssf_period(rate_q) - 16'h0001;
    end else begin
      step_cnt_q <= step_cnt_q - 16'h0001;
    end
  end

  // reference: jumps when not paced, else one LSB per step toward target
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      vref_q <= 16'h0000;
    end else if (ramp_q == vssf_pkg::VSSF_FOLLOW) begin
      vref_q <= tgt_q;
    end else if (pacing && step_en && vref_q < tgt_q) begin
      vref_q <= vref_q + 16'h0001;
    end else if (pacing && step_en && vref_q > tgt_q) begin
      vref_q <= vref_q - 16'h0001;
    end
  end

  // outputs
  assign cmd_done       = done_q;
  assign cmd_nack       = nack_q;
  assign cmd_rdata      = rdata_q;
  assign vref_out       = vref_q;
  assign slew_rate_sel  = rate_q;
  assign nvm_store      = store_q;
  assign nvm_scale_word = nvm_word_q;
  assign set_cml        = cml_q;
  assign set_ivd        = ivd_q;
  assign set_ivc        = ivc_q;
  assign set_oth        = clamp_q;
  assign set_vfw        = clamp_q;
  assign set_vout_warn  = clamp_q;
  // alert request for any of the three fault paths
  assign alert_req      = cml_q || ivc_q || clamp_q;
endmodule

// ---- bench/vssf_regs_assertions.sv ----
// checker for the command port of the slew, scale and floor registers
// assumes it is bound to vssf_regs and sees only its ports
`timescale 1ns/1ns
module vssf_regs_assertions (
  input logic        clk,
  input logic        reset_n,
  input logic        cmd_valid,
  input logic        cmd_write,
  input logic [7:0]  cmd_code,
  input logic [15:0] cmd_wdata,
  input logic        cmd_done,
  input logic        cmd_nack,
  input logic [15:0] cmd_rdata,
  input logic        loop_slave_pin,
  input logic        output_on,
  input logic        nvm_store,
  input logic        set_cml,
  input logic        set_ivd,
  input logic        set_ivc,
  input logic        set_oth,
  input logic        set_vfw,
  input logic        set_vout_warn,
  input logic        alert_req
);
  logic [2:0] pin_hist_q;
  logic [7:0] code_q;
  logic       rd_q;
  // the strap goes through two flops, so only trust it once the three stored samples and the current one are all steady
  wire master_ok = (pin_hist_q == 3'h0) && !loop_slave_pin;
  wire bad_scale = (cmd_wdata[2:0] != vssf_pkg::SCALE_ONE)
                && (cmd_wdata[2:0] != vssf_pkg::SCALE_HALF);
  wire rd_ok     = cmd_done && !cmd_nack && rd_q;
  // remember strap history and the request being answered
  always_ff @(posedge clk) begin
    pin_hist_q <= {pin_hist_q[1:0], loop_slave_pin};
    code_q     <= cmd_code;
    rd_q       <= cmd_valid && !cmd_write;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_done_next: assert property (cmd_valid |=> cmd_done)
    else $error("no done after request");
  chk_done_cause: assert property (cmd_done |-> $past(cmd_valid))
    else $error("done without request");
  chk_slew_exp: assert property (rd_ok && code_q == vssf_pkg::CMD_SLEW
    |-> cmd_rdata[15:11] == vssf_pkg::SLEW_EXP) else $error("slew exponent wrong");
  chk_scale_fixed: assert property (rd_ok && code_q == vssf_pkg::CMD_SCALE
    |-> cmd_rdata[15:3] == {vssf_pkg::SCALE_EXP, 8'h00}) else $error("scale fixed bits");
  chk_floor_top: assert property (rd_ok && code_q == vssf_pkg::CMD_FLOOR
    |-> cmd_rdata[15:12] == 4'h0) else $error("floor top bits");
  chk_bad_scale: assert property (cmd_valid && cmd_write && master_ok
    && cmd_code == vssf_pkg::CMD_SCALE && bad_scale
    |=> set_cml && set_ivd && alert_req && !cmd_nack) else $error("bad scale not flagged");
  chk_slave_refuse: assert property (cmd_valid && cmd_code == vssf_pkg::CMD_FLOOR
    && pin_hist_q == 3'h7 && loop_slave_pin
    |=> cmd_nack && set_ivc && alert_req) else $error("slave did not refuse");
  chk_store_pulse: assert property (cmd_valid && cmd_write
    && cmd_code == vssf_pkg::CMD_STORE_ALL |=> nvm_store && !cmd_nack)
    else $error("store not issued");
  chk_clamp_flags: assert property (set_oth
    |-> set_vfw && set_vout_warn && alert_req && $past(output_on))
    else $error("clamp flags incomplete");
  cov_clamp: cover property (set_oth);
  cov_refuse: cover property (set_ivc);
  cov_bad: cover property (set_cml);
endmodule
bind vssf_regs vssf_regs_assertions i_vssf_regs_assertions (.*);

// ---- bench/vssf_host_model.sv ----
// pmbus host stand-in: one command word at a time on the command port
// assumes the block answers exactly one cycle after it takes a request
`timescale 1ns/1ns
module vssf_host_model (
  input  logic        clk,
  output logic        cmd_valid,
  output logic        cmd_write,
  output logic [7:0]  cmd_code,
  output logic [15:0] cmd_wdata,
  input  logic        cmd_done,
  input  logic        cmd_nack,
  input  logic [15:0] cmd_rdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // one transfer: request held one cycle, answer taken in the done cycle
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [1:0] st, output logic [15:0] rd);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code  <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~d;  // no stale word left for the block to reuse
    // the answer stands only in the cycle after the taking edge
    #1;
    st = {cmd_done, cmd_nack};
    rd = cmd_rdata;
  endtask
endmodule

// ---- bench/vssf_regs_tb_top.sv ----
// self-checking bench for the slew, scale and floor command registers
// assumes the pacing step is shortened to 8000 so ramps settle quickly
`timescale 1ns/1ns
module vssf_regs_tb_top;
  localparam logic [7:0]  SLEW = vssf_pkg::CMD_SLEW;
  localparam logic [7:0]  SCL  = vssf_pkg::CMD_SCALE;
  localparam logic [7:0]  FLR  = vssf_pkg::CMD_FLOOR;
  localparam logic [15:0] OK   = 16'h0002;
  localparam logic [15:0] NK   = 16'h0003;
  localparam logic [10:0] EDGE_M [14] = '{11'h005, 11'h006, 11'h007, 11'h008, 11'h00C,
    11'h00D, 11'h011, 11'h012, 11'h019, 11'h01A, 11'h02F, 11'h030, 11'h04F, 11'h050};
  localparam logic [15:0] EDGE_S [14] = '{0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 6, 7};
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cmd_valid, cmd_write, cmd_done, cmd_nack, nvm_store, alert_req;
  logic        set_cml, set_ivd, set_ivc, set_oth, set_vfw, set_vout_warn;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, vref_out, nvm_scale_word, rd;
  logic [2:0]  slew_rate_sel;
  logic [1:0]  st;
  logic        loop_slave_pin = 1'b0;
  logic        output_on = 1'b0;
  logic        toff_delay_active = 1'b1;
  logic        soft_ramp_active = 1'b0;
  logic        target_attempt = 1'b0;
  logic [15:0] effective_output_target = 16'h0200;
  logic [15:0] vout_max = 16'h069A;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cycles = 0;
  wire [15:0]  flags = {8'h00, set_cml, set_ivd, set_ivc, set_oth, set_vfw,
                        set_vout_warn, alert_req, nvm_store};
  vssf_regs #(.STEP_UV_X1000(8000)) i_vssf_regs (.*);
  vssf_host_model i_vssf_host_model (.*);
  always #2 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d,
                    input logic [15:0] sx, input logic [15:0] fx);
    i_vssf_host_model.xfer(w, c, d, st, rd);
    chk({14'h0, st}, sx, "status");
    chk(flags, fx, "flags");
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] exp);
    op(1'b0, c, 16'h0000, OK, 16'h0000);
    chk(rd, exp, "read word");
  endtask
  // clamp flags come one cycle after the done cycle
  task automatic late_flags(input logic [15:0] fx);
    @(posedge clk);
    #1;
    chk(flags, fx, "late flags");
  endtask
  task automatic attempt(input logic [15:0] eq);
    @(posedge clk);
    effective_output_target     <= eq;
    target_attempt <= 1'b1;
    @(posedge clk);
    target_attempt <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard, well above the few thousand cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk({13'h0, slew_rate_sel}, 16'h0006, "reset rate");
    rdc(SLEW, 16'hD03C);
    rdc(SCL, 16'hF004);
    rdc(FLR, 16'h00B3);
    op(1'b1, SLEW, 16'hFFFF, OK, 16'h0000);
    rdc(SLEW, 16'hD7FF);
    foreach (EDGE_M[i]) begin
      op(1'b1, SLEW, {5'h00, EDGE_M[i]}, OK, 16'h0000);
      late_flags(16'h0000);
      chk({13'h0, slew_rate_sel}, EDGE_S[i], "bucket");
    end
    op(1'b1, SLEW, 16'h003C, OK, 16'h0000);
    // ratio set before the floor is programmed
    op(1'b1, SCL, 16'hFFFA, OK, 16'h0000);
    rdc(SCL, 16'hF002);
    op(1'b1, SCL, 16'h0005, OK, 16'h00C2);
    rdc(SCL, 16'hF002);
    op(1'b1, vssf_pkg::CMD_STORE_ALL, 16'h0000, OK, 16'h0001);
    chk(nvm_scale_word, 16'hF002, "stored word");
    op(1'b1, FLR, 16'hF600, OK, 16'h0000);
    rdc(FLR, 16'h0600);
    @(posedge clk);
    output_on <= 1'b1;
    op(1'b1, FLR, 16'h0700, OK, 16'h0000);
    late_flags(16'h001E);
    op(1'b1, FLR, 16'h0166, OK, 16'h0000);
    late_flags(16'h0000);
    attempt(16'h0100);
    late_flags(16'h001E);
    repeat (1200) @(posedge clk);
    chk(vref_out, 16'h00B3, "floor ref");
    vout_max <= 16'h0100;
    attempt(16'h0080);
    repeat (1200) @(posedge clk);
    chk(vref_out, 16'h0080, "max dominates");
    // a soft ramp bypasses the slew pacer, so the reference jumps at once
    @(posedge clk);
    soft_ramp_active <= 1'b1;
    attempt(16'h0200);
    repeat (4) @(posedge clk);
    #1;
    chk(vref_out, 16'h0100, "soft ramp follow");
    @(posedge clk);
    soft_ramp_active <= 1'b0;
    op(1'b1, SCL, 16'h0004, OK, 16'h0000);
    rdc(SCL, 16'hF004);
    @(posedge clk);
    loop_slave_pin <= 1'b1;
    repeat (3) @(posedge clk);
    op(1'b1, SCL, 16'h0002, NK, 16'h0022);
    op(1'b0, FLR, 16'h0000, NK, 16'h0022);
    @(posedge clk);
    loop_slave_pin <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(SCL, 16'hF004);
    op(1'b0, 8'h55, 16'h0000, NK, 16'h0000);
    finish_test();
  end
endmodule
